// >>> core/thc_pkg.sv
// Shared constants, state codes and helpers of the touch host command interpreter
package thc_pkg;

  // ****************************************
  // Packet framing and identifiers
  // ****************************************
  localparam logic [7:0] BOOT_RESP_LEN   = 8'h02;
  localparam logic [7:0] ACK_RESP_LEN    = 8'h02;
  localparam logic [7:0] ACK_ID          = 8'hf0;
  localparam logic [7:0] GETP_RESP_LEN   = 8'h05;
  localparam logic [7:0] SETP_CMD_LEN    = 8'h0b;
  localparam logic [7:0] GETP_CMD_MIN    = 8'h03;

  localparam logic [7:0] CMD_LOOPBACK    = 8'h04;
  localparam logic [7:0] CMD_BASELINE    = 8'hfb;
  localparam logic [7:0] CMD_REVISION    = 8'hff;
  localparam logic [7:0] CMD_FLASH_READ  = 8'h17;
  localparam logic [7:0] CMD_BOOT_ENTER  = 8'h55;
  localparam logic [7:0] CMD_PASSTHROUGH = 8'hfc;
  localparam logic [7:0] CMD_PARAM_WRITE = 8'he0;
  localparam logic [7:0] CMD_PARAM_READ  = 8'he1;

  localparam logic [7:0] BCMD_EXIT       = 8'h10;
  localparam logic [7:0] BCMD_SESSION    = 8'h11;
  localparam logic [7:0] BCMD_ERASE      = 8'h12;
  localparam logic [7:0] BCMD_ADDRESS    = 8'h13;
  localparam logic [7:0] BCMD_LOAD       = 8'h14;
  localparam logic [7:0] BCMD_WRITE      = 8'h15;
  localparam logic [7:0] BCMD_VALIDATE   = 8'h16;
  localparam logic [7:0] BLEN_ONE        = 8'h01;
  localparam logic [7:0] BLEN_SESSION    = 8'h0a;
  localparam logic [7:0] BLEN_ADDRESS    = 8'h05;
  localparam logic [7:0] BLEN_LOAD_MIN   = 8'h05;
  localparam logic [7:0] BLEN_FLASH      = 8'h03;

  localparam logic [7:0] BST_OK          = 8'h00;
  localparam logic [7:0] BST_BAD_ID      = 8'h0c;
  localparam logic [7:0] BST_BAD_COUNT   = 8'h0d;

  // ****************************************
  // Parameter registers
  // ****************************************
  localparam logic [15:0] PAR_ADDR_MODE    = 16'h0082;
  localparam logic [15:0] PAR_ADDR_MODMASK = 16'h0084;
  localparam logic [7:0]  MODE_RST         = 8'h00;
  localparam logic [7:0]  MODE_PLANAR_SPATIAL = 8'h00;
  localparam logic [7:0]  MODE_CAP_ONLY    = 8'h01;
  localparam logic [7:0]  MODE_PASSTHROUGH = 8'h02;
  localparam logic [7:0]  MODE_STANDBY     = 8'h04;
  localparam logic [7:0]  MODE_DOZE        = 8'h05;
  localparam logic [7:0]  MODE_INVALID     = 8'hff;
  localparam int          MM_DECODE        = 11;
  localparam int          MM_DIGITIZER     = 10;
  localparam int          MM_BASELINE      = 9;
  localparam int          MM_FREQ_HOP      = 8;
  localparam int          MM_ROTATION      = 7;
  localparam int          MM_SLIDE         = 6;
  localparam int          MM_QUICK_STROKE  = 5;
  localparam int          MM_MUTUAL_SCAN   = 2;
  localparam int          MM_GESTURE       = 0;
  localparam logic [15:0] MODMASK_RST      = 16'h0f01;
  localparam logic [15:0] MODMASK_IMPL     = 16'h0fe5;

  typedef enum logic [3:0] {
    ST_LEN  = 4'b0001,
    ST_BODY = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_SEND = 4'b1000
  } thc_state_e;

  function automatic logic thc_mode_valid(input logic [7:0] m);
    return (m == MODE_PLANAR_SPATIAL) || (m == MODE_CAP_ONLY) || (m == MODE_PASSTHROUGH) ||
           (m == MODE_STANDBY) || (m == MODE_DOZE);
  endfunction : thc_mode_valid

endpackage : thc_pkg

// >>> core/thc_param_regs.sv
// Operating mode and module enable parameter registers
`timescale 1ns/1ps
`default_nettype none
module thc_param_regs
  import thc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // Masked write port
  input  wire logic        wr_en_i,
  input  wire logic [15:0] wr_addr_i,
  input  wire logic [31:0] wr_val_i,
  input  wire logic [31:0] wr_mask_i,
  // Register contents
  output logic      [7:0]  mode_o,
  output logic             mode_invalid_o,
  output logic      [15:0] modmask_o
);

  logic [7:0]  mode_d;
  logic [15:0] modmask_d;

  assign mode_d    = (mode_o & ~wr_mask_i[7:0]) | (wr_val_i[7:0] & wr_mask_i[7:0]);
  // Unimplemented bits are stripped so they can never read back set
  assign modmask_d = ((modmask_o & ~wr_mask_i[15:0]) | (wr_val_i[15:0] & wr_mask_i[15:0]))
                     & MODMASK_IMPL; // see R16

  // ****************************************
  // Register updates
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_o         <= MODE_RST;
      mode_invalid_o <= 1'b0;
    end else if (ce_i && wr_en_i && wr_addr_i == PAR_ADDR_MODE) begin // see R04
      mode_o         <= mode_d;
      mode_invalid_o <= !thc_mode_valid(mode_d); // see R03
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      modmask_o <= MODMASK_RST; // see R05 see R06 see R07 see R08
    end else if (ce_i && wr_en_i && wr_addr_i == PAR_ADDR_MODMASK) begin
      modmask_o <= modmask_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_MODE_DECODE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R03
    mode_invalid_o == !thc_mode_valid(mode_o))
    else $error("mode invalid flag disagrees with mode");

  AST_MODE_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R04
    (ce_i && wr_en_i && wr_addr_i == PAR_ADDR_MODE) |=> mode_o == $past(mode_d))
    else $error("mode write not applied");

  AST_MASK_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R05
    (ce_i && wr_en_i && wr_addr_i == PAR_ADDR_MODMASK && wr_mask_i[15:0] == 16'hffff)
      |=> modmask_o == ($past(wr_val_i[15:0]) & MODMASK_IMPL))
    else $error("module enable write not applied");

  AST_MASK_RSVD: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R16
    (modmask_o & ~MODMASK_IMPL) == 16'h0000)
    else $error("unimplemented enable bit set");

endmodule : thc_param_regs
`default_nettype wire

// >>> core/thc_core.sv
// Packet receiver, command decoder and response sender
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: Bootloader reply: length two, echoed ID, status
// R02: Status zero ok, 0x0c unknown, 0x0d count
// R03: Mode codes 0,1,2,4,5 valid; 0xff invalid
// R04: Mode register at parameter address 0x0082
// R05: Bits 11,10 decode and digitizer, reset one
// R06: Bits 9,8 baseline and frequency, reset one
// R07: Bits 7,6,5 gesture event reports, reset zero
// R08: Bit 2 mutual scan zero, bit 0 one
// R09: Dispatch 0x04 loopback, 0xfb baseline, 0xff revision
// R10: Dispatch 0x17 flash, 0x55 boot, 0xfc passthrough
// R11: 0xe0 parameter write, 0xe1 parameter read
// R12: Loopback returns received packet unchanged
// R13: Loopback length is payload plus one, uninterpreted
// R14: Baseline command length one triggers re-acquire
// R15: Application ack: two, 0xf0, command ID
// R16: Unimplemented enable bits read zero, ignore writes
module thc_core
  import thc_pkg::*;
#(
  parameter int PKT_DEPTH = 256
) (
  // Clock, reset, enable
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // Command byte stream from host
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  // Response byte stream to host
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  // Controller status and configuration
  output logic             boot_mode_o,
  output logic             baseline_refresh_o,
  output logic      [7:0]  operating_mode_select_o,
  output logic             mode_invalid_o,
  output logic      [15:0] module_enable_mask_o
);

  localparam int PW = $clog2(PKT_DEPTH);

  thc_state_e  st_q;
  logic [7:0]  pkt_q [PKT_DEPTH];
  logic [7:0]  resp_q [9];
  logic [7:0]  len_q;
  logic [7:0]  rx_cnt_q;
  logic [7:0]  tx_idx_q;
  logic [3:0]  resp_last_q;
  logic        echo_q;
  logic        take;
  logic [7:0]  cmd_id;
  logic [15:0] par_addr;
  logic [31:0] par_val;
  logic        par_wr;
  logic [31:0] par_mask;
  logic [31:0] par_rd;
  logic [7:0]  tx_byte;
  logic        tx_last;
  logic        exec_go;

  // Bytes past the buffer are counted but not stored and read back as zero
  function automatic logic [7:0] pkt_at(input logic [7:0] idx);
    return (32'(idx) < PKT_DEPTH) ? pkt_q[idx[PW-1:0]] : 8'h00;
  endfunction : pkt_at

  function automatic logic [7:0] boot_status(input logic [7:0] id, input logic [7:0] n);
    logic ok;
    ok = 1'b0;
    unique case (id)
      BCMD_EXIT, BCMD_ERASE, BCMD_WRITE, BCMD_VALIDATE, CMD_REVISION: ok = (n == BLEN_ONE);
      BCMD_SESSION: ok = (n == BLEN_SESSION);
      BCMD_ADDRESS: ok = (n == BLEN_ADDRESS);
      BCMD_LOAD:    ok = (n >= BLEN_LOAD_MIN);
      CMD_FLASH_READ: ok = (n == BLEN_FLASH);
      default: return BST_BAD_ID; // see R02
    endcase
    return ok ? BST_OK : BST_BAD_COUNT; // see R02
  endfunction : boot_status

  assign take     = ce_i && rx_valid_i && rx_ready_o;
  assign exec_go  = ce_i && st_q == ST_EXEC;
  assign cmd_id   = pkt_at(8'd0);
  assign par_addr = {pkt_at(8'd2), pkt_at(8'd1)};
  assign par_val  = {pkt_at(8'd6), pkt_at(8'd5), pkt_at(8'd4), pkt_at(8'd3)};
  assign par_mask = {pkt_at(8'd10), pkt_at(8'd9), pkt_at(8'd8), pkt_at(8'd7)};
  assign par_wr   = exec_go && !boot_mode_o && cmd_id == CMD_PARAM_WRITE
                    && len_q == SETP_CMD_LEN; // see R11
  assign par_rd   = (par_addr == PAR_ADDR_MODE)    ? {24'h000000, operating_mode_select_o} :
                    (par_addr == PAR_ADDR_MODMASK) ? {16'h0000, module_enable_mask_o} :
                    32'h00000000;
  // Loopback byte 0 is the length, the rest come straight from the buffer
  assign tx_byte  = echo_q ? ((tx_idx_q == 8'd0) ? len_q : pkt_at(tx_idx_q - 8'd1))
                           : resp_q[tx_idx_q[3:0]]; // see R12
  assign tx_last  = echo_q ? (tx_idx_q == len_q) : (tx_idx_q[3:0] == resp_last_q);

  // ****************************************
  // Parameter registers
  // ****************************************
  thc_param_regs u_regs (
    .sys_clk_i      (sys_clk_i),
    .rst_b_i        (rst_b_i),
    .ce_i           (ce_i),
    .wr_en_i        (par_wr),
    .wr_addr_i      (par_addr),
    .wr_val_i       (par_val),
    .wr_mask_i      (par_mask),
    .mode_o         (operating_mode_select_o),
    .mode_invalid_o (mode_invalid_o),
    .modmask_o      (module_enable_mask_o)
  );

  // ****************************************
  // Packet buffer
  // ****************************************
  // Payload is stored verbatim, never inspected for loopback
  always_ff @(posedge sys_clk_i) begin
    if (take && st_q == ST_BODY && 32'(rx_cnt_q) < PKT_DEPTH) begin
      pkt_q[rx_cnt_q[PW-1:0]] <= rx_data_i; // see R13
    end
  end

  // ****************************************
  // Receive, decode and send
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q               <= ST_LEN;
      rx_ready_o         <= 1'b1;
      len_q              <= 8'h00;
      rx_cnt_q           <= 8'h00;
      tx_idx_q           <= 8'h00;
      tx_valid_o         <= 1'b0;
      tx_data_o          <= 8'h00;
      resp_last_q        <= 4'h0;
      echo_q             <= 1'b0;
      boot_mode_o        <= 1'b0;
      baseline_refresh_o <= 1'b0;
      for (int i = 0; i < 9; i++) begin
        resp_q[i] <= 8'h00;
      end
    end else if (ce_i) begin
      baseline_refresh_o <= 1'b0;
      unique case (st_q)
        ST_LEN: begin
          if (take && rx_data_i != 8'h00) begin
            len_q    <= rx_data_i;
            rx_cnt_q <= 8'h00;
            st_q     <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (take) begin
            rx_cnt_q <= rx_cnt_q + 8'd1;
            if (rx_cnt_q == len_q - 8'd1) begin
              rx_ready_o <= 1'b0;
              st_q       <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          tx_idx_q    <= 8'h00;
          echo_q      <= 1'b0;
          resp_q[0]   <= ACK_RESP_LEN; // see R15
          resp_q[1]   <= ACK_ID;
          resp_q[2]   <= cmd_id;
          resp_last_q <= 4'd2;
          st_q        <= ST_SEND;
          if (boot_mode_o) begin
            resp_q[0] <= BOOT_RESP_LEN; // see R01
            resp_q[1] <= cmd_id;
            resp_q[2] <= boot_status(cmd_id, len_q);
            if (cmd_id == BCMD_EXIT && len_q == BLEN_ONE) begin
              boot_mode_o <= 1'b0;
            end
          end else begin
            unique case (cmd_id) // see R09 see R10
              CMD_LOOPBACK: echo_q <= 1'b1; // see R12
              CMD_BASELINE: baseline_refresh_o <= (len_q == BLEN_ONE); // see R14
              CMD_BOOT_ENTER: boot_mode_o <= 1'b1;
              CMD_REVISION, CMD_FLASH_READ, CMD_PASSTHROUGH, CMD_PARAM_WRITE: begin
              end
              CMD_PARAM_READ: begin
                if (len_q >= GETP_CMD_MIN) begin // see R11
                  resp_q[0]   <= GETP_RESP_LEN;
                  resp_q[1]   <= CMD_PARAM_READ;
                  resp_q[2]   <= par_rd[7:0];
                  resp_q[3]   <= par_rd[15:8];
                  resp_q[4]   <= par_rd[23:16];
                  resp_q[5]   <= par_rd[31:24];
                  resp_q[6]   <= ACK_RESP_LEN;
                  resp_q[7]   <= ACK_ID;
                  resp_q[8]   <= CMD_PARAM_READ;
                  resp_last_q <= 4'd8;
                end
              end
              default: begin
                // Unknown application IDs get no answer
                rx_ready_o <= 1'b1;
                st_q       <= ST_LEN;
              end
            endcase
          end
        end
        ST_SEND: begin
          // A bubble between bytes trades throughput for a simple handshake
          if (!tx_valid_o) begin
            tx_valid_o <= 1'b1;
            tx_data_o  <= tx_byte;
          end else if (tx_ready_i) begin
            tx_valid_o <= 1'b0;
            tx_idx_q   <= tx_idx_q + 8'd1;
            if (tx_last) begin
              rx_ready_o <= 1'b1;
              st_q       <= ST_LEN;
            end
          end
        end
        default: begin
          st_q <= ST_LEN;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_BOOT_FORMAT: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R01
    (exec_go && boot_mode_o) |=> resp_q[0] == 8'h02 && resp_q[1] == $past(cmd_id)
      && resp_last_q == 4'd2 && !echo_q)
    else $error("bootloader reply malformed");

  AST_BOOT_UNKNOWN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R02
    (exec_go && boot_mode_o && cmd_id == 8'h42) |=> resp_q[2] == 8'h0c)
    else $error("unknown bootloader ID status wrong");

  AST_LOOPBACK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R09
    (exec_go && !boot_mode_o && cmd_id == 8'h04) |=> echo_q && st_q == ST_SEND)
    else $error("loopback not dispatched");

  AST_ECHO_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R12
    (st_q == ST_SEND && echo_q && tx_valid_o && tx_idx_q == 8'd0) |-> tx_data_o == len_q)
    else $error("loopback length byte changed");

  AST_BASELINE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R14
    (exec_go && !boot_mode_o && cmd_id == 8'hfb && len_q == 8'h01)
      |=> baseline_refresh_o ##1 !baseline_refresh_o)
    else $error("baseline refresh pulse wrong");

  AST_BOOT_ENTER: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R10
    (exec_go && !boot_mode_o && cmd_id == 8'h55) |=> boot_mode_o && resp_q[2] == 8'h55)
    else $error("boot entry not taken");

  AST_ACK: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R15
    (exec_go && !boot_mode_o && cmd_id == 8'he0)
      |=> resp_q[0] == 8'h02 && resp_q[1] == 8'hf0 && resp_q[2] == 8'he0 && resp_last_q == 4'd2)
    else $error("acknowledge packet wrong");

  AST_PARAM_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see R11
    (exec_go && !boot_mode_o && cmd_id == 8'he0 && len_q == 8'h0b && par_addr == 16'h0082
      && par_mask[7:0] == 8'hff) |=> operating_mode_select_o == $past(par_val[7:0]))
    else $error("parameter write not issued");

endmodule : thc_core
`default_nettype wire

// >>> sim/thc_host_model.sv
// Host model that sends command packets and collects response bytes
`timescale 1ns/1ps
`default_nettype none
module thc_host_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Command stream towards the device
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  input  wire logic       rx_ready_i,
  // Response stream from the device
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  // ****************************************
  // Byte transfers
  // ****************************************
  bit slow      = 1'b0;
  bit timed_out = 1'b0;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
  end

  // Length byte of payload plus one is supplied by the caller, sent as given
  task automatic send_pkt(input logic [7:0] pkt[$]);
    int k;
    foreach (pkt[i]) begin
      rx_valid_o = 1'b1;
      rx_data_o  = pkt[i];
      k = 0;
      while (rx_ready_i !== 1'b1 && k < 200) begin
        @(posedge sys_clk_i);
        #1;
        k++;
      end
      if (k == 200) timed_out = 1'b1;
      @(posedge sys_clk_i);
      #1;
    end
    rx_valid_o = 1'b0;
    // Released data shows the inverse, so a stale byte never passes for a fresh one
    rx_data_o  = ~rx_data_o;
  endtask : send_pkt

  // Payload of a loopback reply is only compared, never interpreted
  task automatic recv(input int n, output logic [7:0] got[$]);
    int k;
    got = {};
    repeat (n) begin
      if (slow) begin
        tx_ready_o = 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        tx_ready_o = 1'b1;
      end
      k = 0;
      while (tx_valid_i !== 1'b1 && k < 200) begin
        @(posedge sys_clk_i);
        #1;
        k++;
      end
      if (k == 200) timed_out = 1'b1;
      got.push_back(tx_data_i);
      @(posedge sys_clk_i);
      #1;
    end
  endtask : recv
endmodule : thc_host_model
`default_nettype wire

// >>> sim/touch_host_command_modes_test.sv
// Self-checking testbench of the touch host command interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, ex, ac); end end
module touch_host_command_modes_test
  import thc_pkg::*;
;
  // ****************************************
  // Design, host and clock
  // ****************************************
  logic        sys_clk   = 1'b0;
  logic        rst_b     = 1'b0;
  logic        ce        = 1'b1;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  logic        boot_mode;
  logic        refresh;
  logic [7:0]  mode;
  logic        mode_inv;
  logic [15:0] mask;
  int          mismatches = 0;
  int          checks     = 0;
  int          pulses     = 0;

  thc_core i_thc_core (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .ce_i(ce),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
    .boot_mode_o(boot_mode), .baseline_refresh_o(refresh),
    .operating_mode_select_o(mode), .mode_invalid_o(mode_inv), .module_enable_mask_o(mask));
  thc_host_model i_thc_host_model (.sys_clk_i(sys_clk), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (refresh === 1'b1) pulses++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic xfer(input string nm, input logic [7:0] tx[$], input logic [7:0] ex[$]);
    logic [7:0] got[$];
    i_thc_host_model.send_pkt(tx);
    i_thc_host_model.recv(ex.size(), got);
    if (i_thc_host_model.timed_out) begin
      mismatches++;
      end_of_test();
    end
    foreach (ex[i]) `CHK(nm, ex[i], got[i])
  endtask : xfer

  task automatic set_par(input logic [15:0] a, input logic [31:0] v, input logic [31:0] m);
    xfer("write ack", {SETP_CMD_LEN, CMD_PARAM_WRITE, a[7:0], a[15:8], v[7:0], v[15:8],
      v[23:16], v[31:24], m[7:0], m[15:8], m[23:16], m[31:24]},
      {ACK_RESP_LEN, ACK_ID, CMD_PARAM_WRITE});
  endtask : set_par

  task automatic get_par(input logic [15:0] a, input logic [31:0] v);
    xfer("read reply", {8'h03, CMD_PARAM_READ, a[7:0], a[15:8]}, {GETP_RESP_LEN,
      CMD_PARAM_READ, v[7:0], v[15:8], v[23:16], v[31:24], ACK_RESP_LEN, ACK_ID,
      CMD_PARAM_READ});
  endtask : get_par

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rst_b = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    `CHK("mask reset", 16'h0f01, mask)
    `CHK("mode reset", 8'h00, mode)
    `CHK("boot reset", 1'b0, boot_mode)
    `CHK("ready reset", 1'b1, rx_ready)
    $display("Test reset done");
  endtask : t_reset

  task automatic t_echo();
    i_thc_host_model.slow = 1'b1;
    xfer("echo", {8'h05, 8'h04, 8'h01, 8'h02, 8'h03, 8'ha5},
      {8'h05, 8'h04, 8'h01, 8'h02, 8'h03, 8'ha5});
    i_thc_host_model.slow = 1'b0;
    xfer("echo bare", {8'h01, 8'h04}, {8'h01, 8'h04});
    $display("Test echo done");
  endtask : t_echo

  task automatic t_baseline();
    int p0;
    p0 = pulses;
    xfer("baseline", {8'h01, 8'hfb}, {8'h02, 8'hf0, 8'hfb});
    `CHK("refresh pulses", p0 + 1, pulses)
    xfer("baseline long", {8'h02, 8'hfb, 8'h00}, {8'h02, 8'hf0, 8'hfb});
    `CHK("refresh none", p0 + 1, pulses)
    $display("Test baseline done");
  endtask : t_baseline

  task automatic t_acks();
    logic [7:0] ids[3] = '{8'hff, 8'h17, 8'hfc};
    foreach (ids[i]) xfer("ack", {8'h01, ids[i]}, {8'h02, 8'hf0, ids[i]});
    $display("Test acks done");
  endtask : t_acks

  task automatic t_mode();
    logic [7:0] ms[7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'hff, 8'h03};
    logic       inv;
    foreach (ms[i]) begin
      inv = !(ms[i] == 8'h00 || ms[i] == 8'h01 || ms[i] == 8'h02 || ms[i] == 8'h04 ||
        ms[i] == 8'h05);
      set_par(16'h0082, {24'h000000, ms[i]}, 32'h000000ff);
      get_par(16'h0082, {24'h000000, ms[i]});
      `CHK("mode out", ms[i], mode)
      `CHK("mode invalid", inv, mode_inv)
    end
    // Masked write only touches the low nibble
    set_par(16'h0082, 32'h000000ff, 32'h0000000f);
    `CHK("mode masked", 8'h0f, mode)
    $display("Test mode done");
  endtask : t_mode

  task automatic t_mask();
    get_par(16'h0084, 32'h00000f01);
    set_par(16'h0084, 32'hffffffff, 32'hffffffff);
    get_par(16'h0084, 32'h00000fe5);
    `CHK("mask all", 16'h0fe5, mask)
    set_par(16'h0084, 32'h00000000, 32'h000000e0);
    `CHK("mask events", 16'h0f05, mask)
    set_par(16'h0084, 32'h00000000, 32'hffffffff);
    `CHK("mask clear", 16'h0000, mask)
    $display("Test mask done");
  endtask : t_mask

  task automatic t_boot();
    xfer("boot enter", {8'h01, 8'h55}, {8'h02, 8'hf0, 8'h55});
    `CHK("boot on", 1'b1, boot_mode)
    xfer("boot ok", {8'h01, 8'h12}, {8'h02, 8'h12, 8'h00});
    xfer("boot count", {8'h02, 8'h12, 8'h00}, {8'h02, 8'h12, 8'h0d});
    xfer("boot id", {8'h01, 8'h42}, {8'h02, 8'h42, 8'h0c});
    xfer("boot exit", {8'h01, 8'h10}, {8'h02, 8'h10, 8'h00});
    `CHK("boot off", 1'b0, boot_mode)
    $display("Test boot done");
  endtask : t_boot

  task automatic t_unknown();
    i_thc_host_model.send_pkt({8'h00});
    // Let an edge pass so the release and the next byte never share a time step
    @(posedge sys_clk);
    #1;
    i_thc_host_model.send_pkt({8'h01, 8'h33});
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      `CHK("silent", 1'b0, tx_valid)
    end
    `CHK("ready back", 1'b1, rx_ready)
    xfer("after skip", {8'h01, 8'hff}, {8'h02, 8'hf0, 8'hff});
    $display("Test unknown done");
  endtask : t_unknown

  // Enable low holds the decoder in place, so no reply appears until it returns
  task automatic t_freeze();
    logic [7:0] got[$];
    logic [7:0] ex[3] = '{8'h02, 8'hf0, 8'hff};
    i_thc_host_model.send_pkt({8'h01, 8'hff});
    ce = 1'b0;
    repeat (5) begin
      @(posedge sys_clk);
      #1;
      `CHK("frozen valid", 1'b0, tx_valid)
      `CHK("frozen ready", 1'b0, rx_ready)
    end
    ce = 1'b1;
    i_thc_host_model.recv(3, got);
    if (i_thc_host_model.timed_out) begin
      mismatches++;
      end_of_test();
    end
    foreach (ex[i]) `CHK("thawed ack", ex[i], got[i])
    $display("Test freeze done");
  endtask : t_freeze

  initial begin
    t_reset();
    t_echo();
    t_baseline();
    t_acks();
    t_mode();
    t_mask();
    t_unknown();
    t_freeze();
    t_boot();
    t_reset();
    end_of_test();
  end
endmodule : touch_host_command_modes_test
`default_nettype wire
